// ### verilog/hv_cfg_params.svh
/*
  Field positions, reset values, command codes and timing counts
  for the indirect high-voltage configuration registers.
  Assumes a 200 MHz system clock.
*/
`ifndef HV_CFG_PARAMS_SVH
`define HV_CFG_PARAMS_SVH

// ****************************************************************
// command codes
// ****************************************************************
`define HV_CMD_RD_CFG0      8'h00
`define HV_CMD_RD_CFG1      8'h01
`define HV_CMD_WR_CFG0      8'h08
`define HV_CMD_WR_CFG1      8'h09

// ****************************************************************
// reset values and field positions
// ****************************************************************
`define HV_CFG0_RESET       8'h00
`define HV_CFG1_RESET       8'h00
`define HV_CFG0_THERM_DIS   7
`define HV_CFG0_OSC_EN      6
`define HV_CFG0_BSD_EN      5
`define HV_CFG0_WAKE_HI     4
`define HV_CFG0_PSM_EN      3
`define HV_CFG0_LVF_EN      2
`define HV_CFG0_LIN_HI      1
`define HV_CFG0_LIN_LO      0
`define HV_CFG1_ATT_DIAG    7

// ****************************************************************
// timing
// ****************************************************************
`define HV_CLK_MHZ          200
`define HV_LATENCY_US       10
`define HV_LATENCY_CYC      (`HV_LATENCY_US * `HV_CLK_MHZ)
`define HV_OSC_START_US     70
`define HV_OSC_START_CYC    (`HV_OSC_START_US * `HV_CLK_MHZ)

`endif

// ### verilog/hv_cfg_pkg.sv
/*
  Types for the indirect high-voltage configuration registers.
  Assumes nothing of its surroundings.
*/
package hv_cfg_pkg;
  typedef enum logic [1:0] {
    LIN_OFF  = 2'h0,
    LIN_RSV1 = 2'h1,
    LIN_ON   = 2'h2,
    LIN_RSV3 = 2'h3
  } lin_mode_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_BUSY = 2'h2
  } cmd_state_e;
endpackage

// ### verilog/hv_indirect_config_regs.sv
/*
  Two indirectly addressed configuration registers for the high-voltage
  circuits, with a command-byte interpreter and data register.
  Assumes command strobes synchronous to clk_i and that software waits
  for busy to fall before issuing another command.
*/
// Summary of operation
// R01: config register zero is eight bits, resets to zero and is reached only through the data register.
// R02: config zero bit 7 set disables thermal shutdown of the wake/status driver, clear enables it.
// R03: config zero bit 6 powers the precision oscillator, which is ready after its start-up time.
// R04: config zero bit 5 set removes the bus pull-up and selects bit-serial mode.
// R05: config zero bit 4 drives the wake pin high, otherwise it is left to the internal pull-down.
// R06: config zero bit 3 enables the supply monitor, whose low-supply event raises the interrupt line if unmasked.
// R07: config zero bit 2 enables the low-voltage flag function.
// R08: config zero bits 1:0 pick the driver mode, only code 10 enabling it.
// R09: config register one is eight bits, resets to zero and is reached only through the data register.
// R10: config one bit 7 switches the attenuator diagnostic current source.
// R11: commands 08 and 09 copy the data low byte into config zero or one.
// R12: commands 00 and 01 read config zero or one back into the data register.
// R13: busy stays set until the previous command completes and new commands must wait.
// R14: a config write updates all eight bits together at command completion.
`timescale 1ns/1ps
`include "hv_cfg_params.svh"

module hv_indirect_config_regs #(
  parameter int LATENCY_CYC   = `HV_LATENCY_CYC,
  parameter int OSC_START_CYC = `HV_OSC_START_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        cmd_wr_i,
  input  wire logic [7:0]  cmd_wdata_i,
  input  wire logic        dat_wr_i,
  input  wire logic [11:0] dat_wdata_i,
  input  wire logic        supply_low_i,
  input  wire logic        interrupt_mask_i,
  output logic      [7:0]  cmd_rdata_o,
  output logic      [11:0] dat_rdata_o,
  output logic             busy_o,
  output logic             therm_shutdown_en_o,
  output logic             osc_en_o,
  output logic             osc_ready_o,
  output logic             bus_pullup_en_o,
  output logic             bit_serial_mode_o,
  output logic             wake_pin_o,
  output logic             wake_pin_oe_o,
  output logic             supply_monitor_en_o,
  output logic             low_voltage_flag_en_o,
  output logic             lin_driver_en_o,
  output logic             att_diag_en_o,
  output logic             hv_interrupt_line_o
);

  // ****************************************************************
  // state
  // ****************************************************************
  localparam int LW = $clog2(LATENCY_CYC + 1);
  localparam int OW = $clog2(OSC_START_CYC + 1);
  localparam logic [7:0] CFG0_RST = `HV_CFG0_RESET;
  localparam logic [7:0] CFG1_RST = `HV_CFG1_RESET;

  hv_cfg_pkg::cmd_state_e state_r;
  logic [LW-1:0]          lat_cnt_r;
  logic [OW-1:0]          osc_cnt_r;
  logic [7:0]             pend_cmd_r;
  logic [7:0]             hv_config_zero_r;
  logic [7:0]             hv_config_one_r;
  logic [11:0]            hv_indirect_data_r;
  logic                   rd_ok_r;
  logic                   wr_ok_r;
  logic                   done;
  logic                   cmd_ok;
  logic                   is_rd;

  assign done   = (state_r == hv_cfg_pkg::ST_BUSY) && (lat_cnt_r == LW'(1));
  assign is_rd  = (pend_cmd_r == `HV_CMD_RD_CFG0) || (pend_cmd_r == `HV_CMD_RD_CFG1);
  assign cmd_ok = is_rd || (pend_cmd_r == `HV_CMD_WR_CFG0) || (pend_cmd_r == `HV_CMD_WR_CFG1);

  // ****************************************************************
  // command sequencer
  // ****************************************************************
  // commands written while busy are dropped, the pending one is kept
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_r    <= hv_cfg_pkg::ST_IDLE;
      lat_cnt_r  <= '0;
      pend_cmd_r <= 8'h00;
    end else begin
      unique case (state_r)
        hv_cfg_pkg::ST_IDLE: begin
          if (cmd_wr_i) begin
            state_r    <= hv_cfg_pkg::ST_BUSY; // R13
            lat_cnt_r  <= LW'(LATENCY_CYC);
            pend_cmd_r <= cmd_wdata_i;
          end
        end
        hv_cfg_pkg::ST_BUSY: begin
          lat_cnt_r <= lat_cnt_r - LW'(1);
          if (done) begin
            state_r <= hv_cfg_pkg::ST_IDLE; // R13
          end
        end
        default: state_r <= hv_cfg_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_ok_r <= 1'b0;
      wr_ok_r <= 1'b0;
    end else if (done) begin
      rd_ok_r <= cmd_ok && is_rd;
      wr_ok_r <= cmd_ok && !is_rd;
    end
  end

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hv_config_zero_r <= `HV_CFG0_RESET; // R01
      hv_config_one_r  <= `HV_CFG1_RESET; // R09
    end else if (done) begin
      if (pend_cmd_r == `HV_CMD_WR_CFG0) begin
        hv_config_zero_r <= hv_indirect_data_r[7:0]; // R11 R14
      end
      if (pend_cmd_r == `HV_CMD_WR_CFG1) begin
        hv_config_one_r <= hv_indirect_data_r[7:0]; // R11 R14
      end
    end
  end

  // ****************************************************************
  // indirect data register
  // ****************************************************************
  // upper nibble tags the data with its command; software writes are masked there
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hv_indirect_data_r <= 12'h000;
    end else if (done && is_rd) begin
      hv_indirect_data_r <= {pend_cmd_r[3:0],
                             (pend_cmd_r == `HV_CMD_RD_CFG0) ? hv_config_zero_r : hv_config_one_r}; // R12
    end else if (done) begin
      hv_indirect_data_r[11:8] <= pend_cmd_r[3:0];
    end else if (dat_wr_i && state_r == hv_cfg_pkg::ST_IDLE) begin
      hv_indirect_data_r <= {4'h0, dat_wdata_i[7:0]};
    end
  end

  // ****************************************************************
  // oscillator start-up
  // ****************************************************************
  // models start-up delay only; real readiness comes from the analog side
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      osc_cnt_r <= '0;
    end else if (!hv_config_zero_r[`HV_CFG0_OSC_EN]) begin
      osc_cnt_r <= '0;
    end else if (osc_cnt_r != OW'(OSC_START_CYC)) begin
      osc_cnt_r <= osc_cnt_r + OW'(1); // R03
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      osc_ready_o         <= 1'b0;
      hv_interrupt_line_o <= 1'b0;
    end else begin
      osc_ready_o         <= hv_config_zero_r[`HV_CFG0_OSC_EN] && (osc_cnt_r == OW'(OSC_START_CYC)); // R03
      hv_interrupt_line_o <= hv_config_zero_r[`HV_CFG0_PSM_EN] && interrupt_mask_i && supply_low_i; // R06
    end
  end

  assign busy_o                = (state_r == hv_cfg_pkg::ST_BUSY); // R13
  assign cmd_rdata_o           = {5'h00, wr_ok_r, rd_ok_r, busy_o};
  assign dat_rdata_o           = hv_indirect_data_r;

  // ****************************************************************
  // registered control outputs
  // ****************************************************************
  // decoded from the data register on the write edge itself, so the
  // controls move with the config register; a decode after the register
  // could pulse the driver enable while both mode bits change
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      therm_shutdown_en_o   <= !CFG0_RST[`HV_CFG0_THERM_DIS];
      osc_en_o              <= CFG0_RST[`HV_CFG0_OSC_EN];
      bit_serial_mode_o     <= CFG0_RST[`HV_CFG0_BSD_EN];
      bus_pullup_en_o       <= !CFG0_RST[`HV_CFG0_BSD_EN];
      wake_pin_o            <= CFG0_RST[`HV_CFG0_WAKE_HI];
      wake_pin_oe_o         <= CFG0_RST[`HV_CFG0_WAKE_HI];
      supply_monitor_en_o   <= CFG0_RST[`HV_CFG0_PSM_EN];
      low_voltage_flag_en_o <= CFG0_RST[`HV_CFG0_LVF_EN];
      lin_driver_en_o       <= (CFG0_RST[`HV_CFG0_LIN_HI:`HV_CFG0_LIN_LO] == hv_cfg_pkg::LIN_ON);
    end else if (done && (pend_cmd_r == `HV_CMD_WR_CFG0)) begin
      therm_shutdown_en_o   <= !hv_indirect_data_r[`HV_CFG0_THERM_DIS]; // R02 R14
      osc_en_o              <= hv_indirect_data_r[`HV_CFG0_OSC_EN]; // R03
      bit_serial_mode_o     <= hv_indirect_data_r[`HV_CFG0_BSD_EN]; // R04
      bus_pullup_en_o       <= !hv_indirect_data_r[`HV_CFG0_BSD_EN]; // R04
      wake_pin_o            <= hv_indirect_data_r[`HV_CFG0_WAKE_HI]; // R05
      // oe low leaves the pin to its internal pull-down
      wake_pin_oe_o         <= hv_indirect_data_r[`HV_CFG0_WAKE_HI]; // R05
      supply_monitor_en_o   <= hv_indirect_data_r[`HV_CFG0_PSM_EN]; // R06
      low_voltage_flag_en_o <= hv_indirect_data_r[`HV_CFG0_LVF_EN]; // R07
      // reserved mode codes leave the driver off
      lin_driver_en_o       <= (hv_indirect_data_r[`HV_CFG0_LIN_HI:`HV_CFG0_LIN_LO] == hv_cfg_pkg::LIN_ON); // R08
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      att_diag_en_o <= CFG1_RST[`HV_CFG1_ATT_DIAG];
    end else if (done && (pend_cmd_r == `HV_CMD_WR_CFG1)) begin
      att_diag_en_o <= hv_indirect_data_r[`HV_CFG1_ATT_DIAG]; // R10 R14
    end
  end

endmodule // hv_indirect_config_regs

// ### sim/hv_cfg_chk.sv
/* Port-level checker for hv_indirect_config_regs.
   Assumes binding into every instance of that module. */
`timescale 1ns/1ps
module hv_cfg_chk #(
  parameter int LATENCY_CYC   = 4,
  parameter int OSC_START_CYC = 8
) (
  input wire logic        clk_i,
  input wire logic        arst_n_i,
  input wire logic        cmd_wr_i,
  input wire logic        supply_low_i,
  input wire logic        interrupt_mask_i,
  input wire logic [7:0]  cmd_rdata_o,
  input wire logic [11:0] dat_rdata_o,
  input wire logic        busy_o,
  input wire logic        therm_shutdown_en_o,
  input wire logic        osc_en_o,
  input wire logic        osc_ready_o,
  input wire logic        bus_pullup_en_o,
  input wire logic        bit_serial_mode_o,
  input wire logic        wake_pin_o,
  input wire logic        wake_pin_oe_o,
  input wire logic        supply_monitor_en_o,
  input wire logic        low_voltage_flag_en_o,
  input wire logic        lin_driver_en_o,
  input wire logic        att_diag_en_o,
  input wire logic        hv_interrupt_line_o
);
  // ****************
  // busy length counter, wide enough for the full 10 us latency
  // ****************
  logic [15:0] busy_cnt_r;
  logic [8:0]  cfg_w;
  assign cfg_w = {therm_shutdown_en_o, osc_en_o, bit_serial_mode_o, wake_pin_o, supply_monitor_en_o,
                  low_voltage_flag_en_o, lin_driver_en_o, att_diag_en_o, bus_pullup_en_o};
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) busy_cnt_r <= 16'h0000;
    else busy_cnt_r <= busy_o ? busy_cnt_r + 16'h0001 : 16'h0000;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  a_pullup_mode: assert property (bus_pullup_en_o == !bit_serial_mode_o) else $error("pull-up vs serial mode");
  a_wake_drive: assert property (wake_pin_oe_o == wake_pin_o) else $error("wake enable mismatch");
  a_irq_gate: assert property (
    hv_interrupt_line_o == $past(supply_monitor_en_o & interrupt_mask_i & supply_low_i))
    else $error("interrupt line wrong");
  a_cfg_atomic: assert property ($changed(cfg_w) |-> $fell(busy_o)) else $error("config changed mid-command");
  a_busy_rise: assert property (cmd_wr_i && !busy_o |=> busy_o) else $error("busy not raised");
  a_busy_len: assert property ($fell(busy_o) |-> busy_cnt_r == 16'(LATENCY_CYC)) else $error("busy length");
  a_osc_wait: assert property ($rose(osc_ready_o) |-> osc_en_o && $past(osc_en_o, OSC_START_CYC))
    else $error("oscillator ready early");
  a_data_hold: assert property (busy_o && $past(busy_o) |-> $stable(dat_rdata_o)) else $error("data moved");
  a_status_bits: assert property (cmd_rdata_o[0] == busy_o && cmd_rdata_o[7:3] == 5'h00) else $error("status");
  c_write_ok: cover property ($fell(busy_o) && cmd_rdata_o[2]);
  c_osc_ready: cover property ($rose(osc_ready_o));
  c_irq: cover property ($rose(hv_interrupt_line_o));
endmodule // hv_cfg_chk
bind hv_indirect_config_regs hv_cfg_chk #(.LATENCY_CYC(LATENCY_CYC), .OSC_START_CYC(OSC_START_CYC)) i_chk (.*);

// ### sim/tb_hv_indirect_config_regs.sv
/* Self-checking bench for hv_indirect_config_regs.
   Assumes hv_cfg_chk.sv is compiled alongside. */
`timescale 1ns/1ps
module tb_hv_indirect_config_regs;
  localparam int LAT = 4;
  logic        clk_i = 1'b0;
  logic        arst_n_i = 1'b0;
  logic        cmd_wr_i = 1'b0;
  logic [7:0]  cmd_wdata_i = 8'h00;
  logic        dat_wr_i = 1'b0;
  logic [11:0] dat_wdata_i = 12'h000;
  logic        supply_low_i = 1'b0;
  logic        interrupt_mask_i = 1'b0;
  logic [7:0]  cmd_rdata_o;
  logic [11:0] dat_rdata_o;
  logic        busy_o, therm_shutdown_en_o, osc_en_o, osc_ready_o, bus_pullup_en_o, bit_serial_mode_o;
  logic        wake_pin_o, wake_pin_oe_o, supply_monitor_en_o, low_voltage_flag_en_o, lin_driver_en_o;
  logic        att_diag_en_o, hv_interrupt_line_o;
  int          bad_count = 0;
  int          n_compared = 0;
  int          cyc = 0;
  logic [7:0]  vals [5] = '{8'hA6, 8'h59, 8'h03, 8'hFC, 8'h00};

  hv_indirect_config_regs #(.LATENCY_CYC(LAT), .OSC_START_CYC(8)) i_dut (.*);

  initial forever #2.5 clk_i = ~clk_i;
  // ****************
  // access tasks
  // ****************
  task automatic tick(); @(posedge clk_i); #1; endtask
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic load(input logic [7:0] v);
    dat_wr_i = 1'b1;
    dat_wdata_i = {4'h0, v};
    tick();
    dat_wr_i = 1'b0;
  endtask
  // poke fires a data write and a second command while busy; both must be dropped
  task automatic issue(input logic [7:0] c, input logic poke);
    cmd_wr_i = 1'b1;
    cmd_wdata_i = c;
    tick();
    chk({11'h0, busy_o}, 12'h001);
    {dat_wr_i, cmd_wr_i, dat_wdata_i, cmd_wdata_i} =
        poke ? {2'b11, 12'h055, 8'h09} : {2'b00, dat_wdata_i, cmd_wdata_i};
    tick();
    {dat_wr_i, cmd_wr_i} = 2'b00;
    repeat (LAT - 2) tick();
    chk({11'h0, busy_o}, 12'h001);
    tick();
    chk({11'h0, busy_o}, 12'h000);
  endtask
  task automatic wr(input logic [7:0] c, input logic [7:0] v);
    load(v);
    issue(c, 1'b0);
    chk(dat_rdata_o, {c[3:0], v});
    chk({4'h0, cmd_rdata_o}, 12'h004);
  endtask
  task automatic rd(input logic [7:0] c, input logic [7:0] v);
    issue(c, 1'b0);
    chk(dat_rdata_o, {c[3:0], v});
    chk({4'h0, cmd_rdata_o}, 12'h002);
  endtask
  task automatic cfgchk(input logic [7:0] v);
    chk({3'h0, wake_pin_oe_o, therm_shutdown_en_o, osc_en_o, bit_serial_mode_o, wake_pin_o, supply_monitor_en_o,
         low_voltage_flag_en_o, lin_driver_en_o, bus_pullup_en_o},
        {3'h0, v[4], !v[7], v[6], v[5], v[4], v[3], v[2], v[1:0] == 2'b10, !v[5]});
  endtask
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      bad_count++;
      conclude();
    end
  end
  // ****************
  // test sequence
  // ****************
  initial begin
    repeat (6) tick();
    arst_n_i = 1'b1;
    cfgchk(8'h00);
    rd(8'h00, 8'h00);
    rd(8'h01, 8'h00);
    foreach (vals[i]) begin
      wr(8'h08, vals[i]);
      cfgchk(vals[i]);
      rd(8'h00, vals[i]);
    end
    wr(8'h09, 8'h80);
    chk({11'h0, att_diag_en_o}, 12'h001);
    wr(8'h09, 8'h7F);
    chk({11'h0, att_diag_en_o}, 12'h000);
    load(8'h80);
    issue(8'h08, 1'b1);
    chk(dat_rdata_o, 12'h880);
    rd(8'h01, 8'h7F);
    issue(8'h05, 1'b0);
    chk({4'h0, cmd_rdata_o}, 12'h000);
    cfgchk(8'h80);
    wr(8'h08, 8'h4A);
    repeat (6) tick();
    chk({11'h0, osc_ready_o}, 12'h000);
    repeat (4) tick();
    chk({11'h0, osc_ready_o}, 12'h001);
    {interrupt_mask_i, supply_low_i} = 2'b11;
    repeat (2) tick();
    chk({11'h0, hv_interrupt_line_o}, 12'h001);
    interrupt_mask_i = 1'b0;
    repeat (2) tick();
    chk({11'h0, hv_interrupt_line_o}, 12'h000);
    arst_n_i = 1'b0;
    tick();
    arst_n_i = 1'b1;
    cfgchk(8'h00);
    chk({4'h0, cmd_rdata_o}, 12'h000);
    interrupt_mask_i = 1'b1;
    rd(8'h01, 8'h00);
    chk({11'h0, hv_interrupt_line_o}, 12'h000);
    conclude();
  end
endmodule // tb_hv_indirect_config_regs
